// file: mdsi_cfg.svh
`ifndef MDSI_CFG_SVH
`define MDSI_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MDSI_OFF_TXQP    32'h400b001c
`define MDSI_OFF_RXST    32'h400b0020
`define MDSI_OFF_IRQST   32'h400b0024
`define MDSI_OFF_IRQEN   32'h400b0028
`define MDSI_OFF_IRQDIS  32'h400b002c
`define MDSI_OFF_IRQMSK  32'h400b0030

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define MDSI_RXST_W      3
`define MDSI_IRQ_W       14
`define MDSI_RX_NODESC   0
`define MDSI_RX_STORED   1
`define MDSI_RX_OVR      2
`define MDSI_I_MGMT      0
`define MDSI_I_RXCMP     1
`define MDSI_I_RX_USED_DESC_READ     2
`define MDSI_I_TX_USED_DESC_READ     3
`define MDSI_I_TX_UNDERRUN      4
`define MDSI_I_RLE       5
`define MDSI_I_TX_BUFFERS_EXHAUSTED     6
`define MDSI_I_TXCMP     7
`define MDSI_I_RX_OVERRUN_IRQ      10
`define MDSI_I_BUSERR    11
`define MDSI_I_PAUSE     12
`define MDSI_I_PTZ       13

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define MDSI_IRQ_VALID   14'h3cff
`define MDSI_IMR_RESET   14'h3cff
`define MDSI_TXQP_KEEP   32'hfffffffc
`define MDSI_TXQP_RESET  32'h00000000

`endif

// file: mdsi_pkg.sv
`default_nettype none
`include "mdsi_cfg.svh"

package mdsi_pkg;

   // ----------------------------------------------------------------
   // Event pulses from the MAC datapaths, one cycle each
   // ----------------------------------------------------------------
   typedef struct packed {
      logic mgmt_done;            // Management frame finished
      logic rx_complete;          // Frame stored in memory
      logic rx_used_desc_read;    // Rx descriptor read with used bit
      logic rx_desc_fetch_fail;   // Rx descriptor owned by processor
      logic rx_desc_fetch_ok;     // Rx descriptor fetch succeeded
      logic rx_frame_start;       // New receive frame begins
      logic rx_grant_late;        // Rx bus grant came too late
      logic rx_bus_error;         // Rx bus error response
      logic tx_used_desc_read;    // Tx descriptor read with used bit
      logic tx_fetch_late;        // Tx data not fetched in time
      logic tx_bus_error;         // Tx bus error response
      logic tx_used_mid_frame;    // Used descriptor met mid-frame
      logic retry_limit_hit;      // Retry limit exceeded
      logic tx_buffers_exhausted; // Tx buffers ran out mid-frame
      logic tx_complete;          // Frame transmitted
      logic pause_received;       // Valid pause frame received
      logic pause_expired;        // Pause counter reached zero
      logic tx_frame_load;        // Tx DMA moved to next frame
   } mdsi_evt_t;

   // ----------------------------------------------------------------
   // Whole state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0]              txqp;     // Tx queue pointer
      logic [`MDSI_RXST_W-1:0]  rxst;     // Receive status flags
      logic [`MDSI_IRQ_W-1:0]   isr;      // Interrupt status flags
      logic [`MDSI_IRQ_W-1:0]   imr;      // Interrupt mask, 1 = masked
      logic [31:0]              rdata;    // Read data
      logic                     irq;      // Interrupt output
      logic                     pend;     // Rx descriptor retry pending
      logic                     refetch;  // Rx descriptor re-read pulse
      logic                     recover;  // Rx buffer recovery pulse
      logic                     restart;  // Tx queue restart pulse
   } mdsi_state_t;

endpackage : mdsi_pkg

`default_nettype wire

// file: mdsi_top.sv
// Overview of operation
// R01: Tx pointer written by software, reads current frame
// R02: Pointer bits 1:0 kept zero
// R03: Rx status flags cleared by writing one
// R04: No-descriptor flag set on every failed fetch
// R05: Failed fetch re-reads pointer each frame start
// R06: Frame-stored flag set on stored frames
// R07: Overrun flag set, buffer recovered
// R08: Management done interrupt, clear on read
// R09: Receive complete interrupt, clear on read
// R10: Used-bit read interrupts, clear on read
// R11: Tx underrun from four causes, clear on read
// R12: Tx complete, exhausted, retry limit interrupts
// R13: Overrun interrupt follows overrun flag
// R14: Bus error interrupt, clear on read
// R15: Pause received interrupt, clear on read
// R16: Pause time zero interrupt, clear on read
// R17: Enable register unmasks written ones
// R18: Disable register masks written ones
// R19: Mask register reads one when masked
// R20: Zero writes keep mask, unused bits zero
// R21: Interrupt out when unmasked flag set
`timescale 1ns/1ps
`default_nettype none
`include "mdsi_cfg.svh"

module mdsi_top
   import mdsi_pkg::*;
(
   input  wire  logic        clk_sys,         // 50 MHz system clock
   input  wire  logic        rst,             // Synchronous reset
   input  wire  logic [31:0] reg_addr,        // Register byte address
   input  wire  logic [31:0] reg_wdata,       // Write data
   input  wire  logic        reg_wr,          // Write strobe
   input  wire  logic        reg_rd,          // Read strobe
   output       logic [31:0] reg_rdata,       // Read data, cycle after
   input  wire  mdsi_evt_t   evt,             // Datapath event pulses
   input  wire  logic [31:0] tx_frame_ptr,    // Next frame descriptor
   output       logic [31:0] tx_queue_base,   // Pointer to tx DMA
   output       logic        tx_queue_restart,// Pointer rewritten
   output       logic        rx_desc_refetch, // Re-read rx descriptor
   output       logic        rx_buffer_recover,// Recover rx buffer
   output       logic        irq_out          // Interrupt request
);

   // ----------------------------------------------------------------
   // Decode helper
   // ----------------------------------------------------------------
   // True when the address selects the given register
   function automatic logic sel(input logic [31:0] a, input logic [31:0] off);
      sel = (a == off);
   endfunction : sel

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   mdsi_state_t st_q;   // Registered state
   mdsi_state_t st_d;   // Next state

   // Access strobes per register
   logic                  wr_txqp;    // Tx pointer write
   logic                  wr_rxst;    // Rx status write
   logic                  wr_en;      // Enable register write
   logic                  wr_dis;     // Disable register write
   logic                  rd_isr;     // Status read, clears flags
   logic [`MDSI_IRQ_W-1:0] wbits;     // Write data, valid bits only
   logic [`MDSI_RXST_W-1:0] rx_set;   // Rx status set events
   logic [`MDSI_IRQ_W-1:0] irq_set;   // Interrupt set events
   logic                  ovr_evt;    // Rx frame could not be stored

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   assign wr_txqp = reg_wr && sel(reg_addr, `MDSI_OFF_TXQP);
   assign wr_rxst = reg_wr && sel(reg_addr, `MDSI_OFF_RXST);
   assign wr_en   = reg_wr && sel(reg_addr, `MDSI_OFF_IRQEN);
   assign wr_dis  = reg_wr && sel(reg_addr, `MDSI_OFF_IRQDIS);
   assign rd_isr  = reg_rd && sel(reg_addr, `MDSI_OFF_IRQST);
   assign wbits   = reg_wdata[`MDSI_IRQ_W-1:0] & `MDSI_IRQ_VALID; // [R20]
   assign ovr_evt = evt.rx_grant_late || evt.rx_bus_error;

   // ----------------------------------------------------------------
   // Event collection
   // ----------------------------------------------------------------
   // Map datapath pulses onto flag positions
   always_comb
   begin
      rx_set = '0;
      irq_set = '0;
      rx_set[`MDSI_RX_NODESC] = evt.rx_desc_fetch_fail;  // [R04]
      rx_set[`MDSI_RX_STORED] = evt.rx_complete;         // [R06]
      rx_set[`MDSI_RX_OVR]    = ovr_evt;                 // [R07]
      irq_set[`MDSI_I_MGMT]   = evt.mgmt_done;           // [R08]
      irq_set[`MDSI_I_RXCMP]  = evt.rx_complete;         // [R09]
      irq_set[`MDSI_I_RX_USED_DESC_READ]  = evt.rx_used_desc_read;   // [R10]
      irq_set[`MDSI_I_TX_USED_DESC_READ]  = evt.tx_used_desc_read;   // [R10]
      // Any of four underrun causes
      irq_set[`MDSI_I_TX_UNDERRUN]   = evt.tx_fetch_late || evt.tx_bus_error
                              || evt.tx_used_mid_frame || wr_txqp; // [R11]
      irq_set[`MDSI_I_RLE]    = evt.retry_limit_hit;     // [R12]
      irq_set[`MDSI_I_TX_BUFFERS_EXHAUSTED]  = evt.tx_buffers_exhausted;// [R12]
      irq_set[`MDSI_I_TXCMP]  = evt.tx_complete;         // [R12]
      irq_set[`MDSI_I_RX_OVERRUN_IRQ]   = ovr_evt;                 // [R13]
      // Bus error seen by either DMA direction
      irq_set[`MDSI_I_BUSERR] = evt.rx_bus_error || evt.tx_bus_error; // [R14]
      irq_set[`MDSI_I_PAUSE]  = evt.pause_received;      // [R15]
      irq_set[`MDSI_I_PTZ]    = evt.pause_expired;       // [R16]
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.refetch = 1'b0;
      st_d.restart = 1'b0;
      st_d.recover = ovr_evt;                            // [R07]

      // Tx pointer: software write wins over DMA advance
      if (wr_txqp)
      begin
         st_d.txqp = reg_wdata & `MDSI_TXQP_KEEP;        // [R01]
         st_d.restart = 1'b1;
      end
      else if (evt.tx_frame_load)
      begin
         st_d.txqp = tx_frame_ptr & `MDSI_TXQP_KEEP;     // [R01]
      end

      // Rx status: write one clears, set wins over clear
      if (wr_rxst)
      begin
         st_d.rxst = st_q.rxst & ~reg_wdata[`MDSI_RXST_W-1:0]; // [R03]
      end
      st_d.rxst = st_d.rxst | rx_set;                    // [R03]

      // Descriptor retry: re-read on each new frame
      if (evt.rx_desc_fetch_ok)
      begin
         st_d.pend = 1'b0;
      end
      else if (evt.rx_desc_fetch_fail)
      begin
         st_d.pend = 1'b1;
      end
      if (st_q.pend && evt.rx_frame_start)
      begin
         st_d.refetch = 1'b1;                            // [R05]
      end

      // Interrupt status: clear on read, set wins
      if (rd_isr)
      begin
         st_d.isr = '0;                                  // [R08]
      end
      st_d.isr = st_d.isr | irq_set;

      // Mask: enable clears, disable sets
      if (wr_en)
      begin
         st_d.imr = st_d.imr & ~wbits;                   // [R17]
      end
      if (wr_dis)
      begin
         st_d.imr = st_d.imr | wbits;                    // [R18]
      end
      st_d.imr = st_d.imr & `MDSI_IRQ_VALID;             // [R20]

      // Read data for the cycle after the strobe
      st_d.rdata = '0;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `MDSI_OFF_TXQP:   st_d.rdata = st_q.txqp;     // [R01]
            `MDSI_OFF_RXST:   st_d.rdata = {29'h0, st_q.rxst};
            `MDSI_OFF_IRQST:  st_d.rdata = {18'h0, st_q.isr};
            `MDSI_OFF_IRQMSK: st_d.rdata = {18'h0, st_q.imr}; // [R19]
            default:          st_d.rdata = '0;            // Unmapped, write-only
         endcase
      end

      // Interrupt line from next flags and mask
      st_d.irq = |(st_d.isr & ~st_d.imr);                // [R21]
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         st_q      <= '0;
         st_q.txqp <= `MDSI_TXQP_RESET;
         st_q.imr  <= `MDSI_IMR_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata         = st_q.rdata;
   assign tx_queue_base     = st_q.txqp;
   assign tx_queue_restart  = st_q.restart;
   assign rx_desc_refetch   = st_q.refetch;
   assign rx_buffer_recover = st_q.recover;
   assign irq_out           = st_q.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Pointer write reads back aligned and restarts queue
   txqp_write_a: assert property (wr_txqp |=> // [R01]
         tx_queue_base == ($past(reg_wdata) & `MDSI_TXQP_KEEP) && tx_queue_restart)
      else $error("tx pointer write not taken");

   // DMA advance loads the next frame pointer
   txqp_load_a: assert property (evt.tx_frame_load && !wr_txqp |=> // [R01]
         tx_queue_base == ($past(tx_frame_ptr) & `MDSI_TXQP_KEEP))
      else $error("tx pointer advance not taken");

   // Restart pulse only after a pointer write
   restart_only_a: assert property (!wr_txqp |=> !tx_queue_restart) // [R01]
      else $error("tx restart without pointer write");

   // Rx flags rise only on their event
   rxst_noset_a: assert property ((st_q.rxst & ~$past(st_q.rxst) // [R03]
         & ~$past(rx_set)) == '0)
      else $error("rx status set without event");

   // Write one clears a quiet flag
   rxst_clear_a: assert property (wr_rxst && reg_wdata[`MDSI_RX_STORED] // [R03]
         && !evt.rx_complete |=> !st_q.rxst[`MDSI_RX_STORED])
      else $error("rx status not cleared by one");

   // Fetch failure sets flag even during clear
   nodesc_set_a: assert property (evt.rx_desc_fetch_fail // [R04]
         |=> st_q.rxst[`MDSI_RX_NODESC])
      else $error("no-descriptor flag missed");

   // Pending retry re-reads at frame start
   refetch_a: assert property (st_q.pend && evt.rx_frame_start // [R05]
         |=> rx_desc_refetch)
      else $error("descriptor re-read missing");

   // No re-read without a pending failure and a frame start
   no_refetch_a: assert property (!(st_q.pend && evt.rx_frame_start) // [R05]
         |=> !rx_desc_refetch)
      else $error("descriptor re-read without cause");

   // Stored frame sets status flag and interrupt flag
   rx_stored_a: assert property (evt.rx_complete // [R06]
         |=> st_q.rxst[`MDSI_RX_STORED] && st_q.isr[`MDSI_I_RXCMP])
      else $error("stored frame not reported");

   // Overrun sets flag, interrupt and recovery together
   overrun_a: assert property (ovr_evt |=> st_q.rxst[`MDSI_RX_OVR] // [R13]
         && st_q.isr[`MDSI_I_RX_OVERRUN_IRQ] && rx_buffer_recover)
      else $error("overrun not reported");

   // Recovery pulse only after an overrun
   recover_only_a: assert property (!ovr_evt |=> !rx_buffer_recover) // [R07]
      else $error("buffer recovered without overrun");

   // Status read returns flags and clears them
   isr_read_a: assert property (rd_isr && irq_set == '0 |=> // [R08]
         reg_rdata == {18'h0, $past(st_q.isr)} && st_q.isr == '0)
      else $error("status read did not clear");

   // Interrupt flags rise only on their event
   isr_noset_a: assert property ((st_q.isr & ~$past(st_q.isr) // [R08]
         & ~$past(irq_set)) == '0)
      else $error("interrupt flag set without event");

   // Management done raises its flag
   mgmt_set_a: assert property (evt.mgmt_done |=> st_q.isr[`MDSI_I_MGMT]) // [R08]
      else $error("management done flag missed");

   // Used-bit reads raise their own flags
   used_read_a: assert property ( // [R10]
         (evt.rx_used_desc_read |=> st_q.isr[`MDSI_I_RX_USED_DESC_READ])
         and (evt.tx_used_desc_read |=> st_q.isr[`MDSI_I_TX_USED_DESC_READ]))
      else $error("used-bit flag missed");

   // Any of the four underrun causes raises the flag
   tx_underrun_causes_a: assert property (evt.tx_fetch_late || evt.tx_bus_error // [R11]
         || evt.tx_used_mid_frame || wr_txqp |=> st_q.isr[`MDSI_I_TX_UNDERRUN])
      else $error("underrun flag missed");

   // Tx complete, exhausted and retry limit raise their flags
   tx_flags_a: assert property ( // [R12]
         (evt.tx_complete |=> st_q.isr[`MDSI_I_TXCMP])
         and (evt.retry_limit_hit |=> st_q.isr[`MDSI_I_RLE])
         and (evt.tx_buffers_exhausted |=> st_q.isr[`MDSI_I_TX_BUFFERS_EXHAUSTED]))
      else $error("tx flag missed");

   // Bus error from either direction raises its flag
   bus_err_a: assert property (evt.rx_bus_error || evt.tx_bus_error // [R14]
         |=> st_q.isr[`MDSI_I_BUSERR])
      else $error("bus error flag missed");

   // Pause events raise their flags
   pause_a: assert property ( // [R15] [R16]
         (evt.pause_received |=> st_q.isr[`MDSI_I_PAUSE])
         and (evt.pause_expired |=> st_q.isr[`MDSI_I_PTZ]))
      else $error("pause flag missed");

   // Enable write unmasks exactly the written ones
   enable_a: assert property (wr_en && !wr_dis |=> // [R17]
         st_q.imr == ($past(st_q.imr) & ~$past(wbits)))
      else $error("enable write wrong");

   // Disable write masks exactly the written ones
   disable_a: assert property (wr_dis |=> // [R18]
         st_q.imr == (($past(st_q.imr) & ~($past(wr_en) ? $past(wbits) : '0))
                      | $past(wbits)))
      else $error("disable write wrong");

   // Mask read shows mask, unused bits zero
   mask_read_a: assert property (reg_rd && sel(reg_addr, `MDSI_OFF_IRQMSK) // [R19]
         |=> reg_rdata == {18'h0, $past(st_q.imr)} && reg_rdata[9:8] == 2'h0)
      else $error("mask read wrong");

   // Unused mask positions never hold a one
   mask_unused_a: assert property (st_q.imr[9:8] == 2'h0) // [R20]
      else $error("unused mask bit set");

   // Read data stays zero without a read strobe
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) // [R20]
      else $error("read data without read");

   // Interrupt line tracks unmasked flags
   irq_line_a: assert property (irq_out == |(st_q.isr & ~st_q.imr)) // [R21]
      else $error("interrupt line wrong");

   // Main scenarios
   cov_irq_c:     cover property (wr_en ##1 evt.tx_complete ##1 irq_out);
   cov_retry_c:   cover property (evt.rx_desc_fetch_fail ##[1:8] rx_desc_refetch);
   cov_clrset_c:  cover property (rd_isr && evt.mgmt_done ##1 st_q.isr[`MDSI_I_MGMT]);
   cov_overrun_c: cover property (ovr_evt ##1 rx_buffer_recover);
   cov_restart_c: cover property (wr_txqp ##1 tx_queue_restart);

endmodule : mdsi_top

`default_nettype wire

// file: mdsi_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdsi_cfg.svh"

module mdsi_tb_top
   import mdsi_pkg::*;
;

   // ----------------------------------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [17:0] ev;   // Event pulse vector
      logic [31:0] isr;  // Expected interrupt flags
      logic [31:0] rx;   // Expected receive flags
   } mdsi_tb_case_t;

   logic          clk_sys;            // System clock
   logic          rst;                // Synchronous reset
   logic [31:0]   reg_addr;           // Bus address
   logic [31:0]   reg_wdata;          // Bus write data
   logic          reg_wr;             // Write strobe
   logic          reg_rd;             // Read strobe
   logic [31:0]   reg_rdata;          // Bus read data
   mdsi_evt_t     evt;                // Event pulses
   logic [31:0]   tx_frame_ptr;       // Next frame pointer
   logic [31:0]   tx_queue_base;      // Pointer to tx DMA
   logic          tx_queue_restart;   // Pointer rewritten pulse
   logic          rx_desc_refetch;    // Descriptor re-read pulse
   logic          rx_buffer_recover;  // Buffer recovery pulse
   logic          irq_out;            // Interrupt request
   int            bad_count;          // Mismatches seen
   int            checks_done;        // Comparisons made
   mdsi_tb_case_t cases [15];         // One row per flag-setting event source

   // ----------------------------------------------------------------
   // Device under test
   // ----------------------------------------------------------------
   mdsi_top u_dut (
      .clk_sys           (clk_sys),
      .rst               (rst),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .evt               (evt),
      .tx_frame_ptr      (tx_frame_ptr),
      .tx_queue_base     (tx_queue_base),
      .tx_queue_restart  (tx_queue_restart),
      .rx_desc_refetch   (rx_desc_refetch),
      .rx_buffer_recover (rx_buffer_recover),
      .irq_out           (irq_out)
   );

   // ----------------------------------------------------------------
   // Tasks for bus cycles, events and comparisons
   // ----------------------------------------------------------------
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One-cycle write, returns just after the sampling edge
   task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask : bus_wr

   // One-cycle read, data taken in the following cycle
   task automatic chk_rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : chk_rd

   // One-cycle event pulse, returns once its effect is registered
   task automatic pulse(input logic [17:0] v);
      @(posedge clk_sys);
      evt <= mdsi_evt_t'(v);
      @(posedge clk_sys);
      evt <= '0;
      #1;
   endtask : pulse

   // Verdict and end of run
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Tests need about 300 cycles, cut off far beyond
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst = 1'b1; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
      evt = '0; tx_frame_ptr = '0; bad_count = 0; checks_done = 0;
      // Event, expected interrupt flags, expected receive flags
      cases = '{'{18'h20000, 32'h0001, 32'h0}, '{18'h10000, 32'h0002, 32'h2},
                '{18'h08000, 32'h0004, 32'h0}, '{18'h04000, 32'h0000, 32'h1},
                '{18'h00800, 32'h0400, 32'h4}, '{18'h00400, 32'h0c00, 32'h4},
                '{18'h00200, 32'h0008, 32'h0}, '{18'h00100, 32'h0010, 32'h0},
                '{18'h00080, 32'h0810, 32'h0}, '{18'h00040, 32'h0010, 32'h0},
                '{18'h00020, 32'h0020, 32'h0}, '{18'h00010, 32'h0040, 32'h0},
                '{18'h00008, 32'h0080, 32'h0}, '{18'h00004, 32'h1000, 32'h0},
                '{18'h00002, 32'h2000, 32'h0}};
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, unmapped and write-only reads
      chk_rd(`MDSI_OFF_IRQMSK, 32'h00003cff);
      chk_rd(`MDSI_OFF_TXQP, 32'h00000000);
      chk_rd(`MDSI_OFF_RXST, 32'h00000000);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000000);
      chk_rd(`MDSI_OFF_IRQEN, 32'h00000000);
      chk_rd(32'h400b0034, 32'h00000000);
      // Masked source raises no request
      pulse(18'h00008);
      chk({31'h0, irq_out}, 32'h0);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000080);
      bus_wr(`MDSI_OFF_IRQEN, 32'h00000080);
      chk_rd(`MDSI_OFF_IRQMSK, 32'h00003c7f);
      bus_wr(`MDSI_OFF_IRQEN, 32'h00000000);
      bus_wr(`MDSI_OFF_IRQDIS, 32'h00000000);
      bus_wr(`MDSI_OFF_IRQMSK, 32'h00000080);
      chk_rd(`MDSI_OFF_IRQMSK, 32'h00003c7f);
      // Unmasked source drives the request until masked again
      pulse(18'h00008);
      chk({31'h0, irq_out}, 32'h1);
      bus_wr(`MDSI_OFF_IRQDIS, 32'h00000080);
      chk({31'h0, irq_out}, 32'h0);
      chk_rd(`MDSI_OFF_IRQMSK, 32'h00003cff);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000080);
      bus_wr(`MDSI_OFF_IRQEN, 32'hffffffff);
      chk_rd(`MDSI_OFF_IRQMSK, 32'h00000000);
      // Every flag-setting event source, flags cleared on read or by writing one
      for (int i = 0; i < 15; i++)
      begin
         pulse(cases[i].ev);
         chk({31'h0, irq_out}, {31'h0, cases[i].isr != 32'h0});
         chk_rd(`MDSI_OFF_IRQST, cases[i].isr);
         chk_rd(`MDSI_OFF_IRQST, 32'h00000000);
         chk_rd(`MDSI_OFF_RXST, cases[i].rx);
         bus_wr(`MDSI_OFF_RXST, 32'h00000007);
         chk_rd(`MDSI_OFF_RXST, 32'h00000000);
         chk({31'h0, irq_out}, 32'h0);
      end
      // Tx pointer write with bits 1:0 forced to zero, restart, underrun, DMA progress
      bus_wr(`MDSI_OFF_TXQP, 32'hdeadbeeb);
      chk({31'h0, tx_queue_restart}, 32'h1);
      chk(tx_queue_base, 32'hdeadbee8);
      chk_rd(`MDSI_OFF_TXQP, 32'hdeadbee8);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000010);
      chk({31'h0, tx_queue_restart}, 32'h0);
      @(posedge clk_sys);
      tx_frame_ptr <= 32'h00001230;
      pulse(18'h00001);
      chk_rd(`MDSI_OFF_TXQP, 32'h00001230);
      // Write one clears only its flag, writes never set
      pulse(18'h14800);
      chk({31'h0, rx_buffer_recover}, 32'h1);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000402);
      bus_wr(`MDSI_OFF_RXST, 32'h00000002);
      chk_rd(`MDSI_OFF_RXST, 32'h00000005);
      bus_wr(`MDSI_OFF_RXST, 32'h00000005);
      bus_wr(`MDSI_OFF_RXST, 32'hffffffff);
      chk_rd(`MDSI_OFF_RXST, 32'h00000000);
      // Repeated fetch failure sets the flag each time
      pulse(18'h04000);
      chk_rd(`MDSI_OFF_RXST, 32'h00000001);
      bus_wr(`MDSI_OFF_RXST, 32'h00000001);
      pulse(18'h04000);
      chk_rd(`MDSI_OFF_RXST, 32'h00000001);
      // Descriptor re-read at every frame start until a fetch works
      pulse(18'h01000);
      chk({31'h0, rx_desc_refetch}, 32'h1);
      pulse(18'h01000);
      chk({31'h0, rx_desc_refetch}, 32'h1);
      pulse(18'h02000);
      pulse(18'h01000);
      chk({31'h0, rx_desc_refetch}, 32'h0);
      chk({31'h0, rx_buffer_recover}, 32'h0);
      // Status read and new event in one cycle: the event survives
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= `MDSI_OFF_IRQST;
      evt      <= mdsi_evt_t'(18'h20000);
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      evt      <= '0;
      #1;
      chk(reg_rdata, 32'h00000000);
      chk({31'h0, irq_out}, 32'h1);
      chk_rd(`MDSI_OFF_IRQST, 32'h00000001);
      summarize();
   end

endmodule : mdsi_tb_top

`default_nettype wire
